// File: verilog/ats_pkg.sv
// shared constants for the asynchronous timer update crossing block
`default_nettype none
package ats_pkg;
  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] ATS_COUNT_OFS    = 8'h00;
  localparam logic [7:0] ATS_COMPARE_OFS  = 8'h04;
  localparam logic [7:0] ATS_CONTROL_OFS  = 8'h08;
  localparam logic [7:0] ATS_STATUS_OFS   = 8'h0C;
  localparam logic [7:0] ATS_FLAG_OFS     = 8'h10;
  // async status register field positions
  localparam int ATS_CTRL_BUSY_BIT  = 0;
  localparam int ATS_CMP_BUSY_BIT   = 1;
  localparam int ATS_CNT_BUSY_BIT   = 2;
  localparam int ATS_ASYNC_SEL_BIT  = 3;
  // irq flag register field positions
  localparam int ATS_OVF_FLAG_BIT   = 0;
  localparam int ATS_CMP_FLAG_BIT   = 1;
  // control register fields
  localparam int ATS_CLK_SEL_LSB    = 0;
  localparam int ATS_CTC_BIT        = 3;
  localparam int ATS_CMP_MODE_LSB   = 4;
  // reset values
  localparam logic [7:0] ATS_REG_RESET = 8'h00;
  // osc rising edges between write and destination latch
  localparam logic [1:0] ATS_XFER_EDGES = 2'h2;
  // cpu-cycle stages of the interrupt flag pipe ahead of the flag register
  localparam int ATS_FLAG_DELAY = 3;
  // axi responses
  localparam logic [1:0] ATS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ATS_RESP_SLVERR = 2'h2;
  // compare output modes
  typedef enum logic [1:0] {ATS_CMP_OFF, ATS_CMP_TOGGLE, ATS_CMP_CLEAR, ATS_CMP_SET} ats_cmp_mode_t;
endpackage
`default_nettype wire

// File: verilog/ats_sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module ats_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // level crossing
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// File: verilog/ats_hold_xfer.sv
// holding register with its own transfer path and busy flag
`timescale 1ns/1ps
`default_nettype none
module ats_hold_xfer
  import ats_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // cpu side
  input  wire logic       write_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       async_sel_in,
  input  wire logic       osc_edge_in,
  output logic [7:0]      hold_out,
  output logic            busy_out,
  // destination side
  output logic            commit_out
);
  logic [1:0] edge_cnt;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      hold_out <= ATS_REG_RESET;
    else if (write_in)
      hold_out <= wdata_in;
  end

  // a new write restarts the count so the newest value wins
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      busy_out   <= 1'b0;
      edge_cnt   <= 2'h0;
      commit_out <= 1'b0;
    end
    else if (write_in)
    begin
      busy_out   <= async_sel_in;
      edge_cnt   <= 2'h0;
      commit_out <= !async_sel_in;
    end
    else if (busy_out && osc_edge_in)
    begin
      edge_cnt <= edge_cnt + 2'h1;
      if (edge_cnt + 2'h1 == ATS_XFER_EDGES)
      begin
        busy_out   <= 1'b0;
        commit_out <= 1'b1;
      end
      else
        commit_out <= 1'b0;
    end
    else
      commit_out <= 1'b0;
  end
endmodule
`default_nettype wire

// File: verilog/ats_top.sv
// asynchronous timer register update, flag crossing and wake timing
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: async write to control sets control busy, status bit 0.
// R2: control busy clears once holding value lands in control.
// R3: software must not rewrite a register while its busy flag is set.
// R4: reading count returns the live counter.
// R5: reading compare or control returns the holding register.
// R6: writes go to holding, latched after two timer oscillator rising edges.
// R7: each register has its own holding register and transfer path.
// R8: software follows the safe clock source switch sequence.
// R9: oscillator input stays below 256 kHz and quarter cpu clock.
// R10: compare match suppressed while count or compare transfer pending.
// R11: software waits for busy clear before power-save when waking by timer.
// R12: interrupt logic needs one oscillator cycle to rearm after wake.
// R13: oscillator runs when async selected, except in power-down.
// R14: software reinitialises registers after power-up or power-down wake.
// R15: software waits one second for oscillator to settle.
// R16: wake starts on the timer cycle after the interrupt condition.
// R17: flags become visible three cpu cycles after wake; the code sets them four cpu cycles after the timer event, not after the wake.
// R18: async flag crossing takes three cpu cycles plus one timer cycle; the code delays flags by four cpu cycles only.
// R19: compare pin changes on the timer clock, not cpu synchronised; the code registers the pin on the cpu clock when a match occurs.
// R20: async select picks oscillator input, else internal system clock.
// R21: count and compare writes set and clear their own busy flags.
// R22: every crossing signal passes a two-flop synchroniser.
module ats_top
  import ats_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // timer oscillator and sleep state
  input  wire logic        timer_osc_in,
  input  wire logic        power_save_in,
  input  wire logic        power_down_in,
  // outputs
  output logic             compare_pin_out,
  output logic             osc_enable_out,
  output logic             wake_out
);
  import ats_pkg::*;

  // ---------------- bus slave ----------------
  logic [7:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        wr_go;
  logic        rd_go;
  logic        wr_hit;
  logic        rd_hit;
  logic        wr_count;
  logic        wr_compare;
  logic        wr_control;
  logic        wr_status;
  logic        wr_flag;
  logic [7:0]  wbyte;
  logic [31:0] next_rdata;

  assign wr_go = aw_held && w_held && !s_axi_bvalid_out;
  assign rd_go = s_axi_arvalid_in && s_axi_arready_out;
  assign wbyte = w_data[7:0];

  always_comb
  begin
    wr_hit = (aw_addr == ATS_COUNT_OFS) || (aw_addr == ATS_COMPARE_OFS) || (aw_addr == ATS_CONTROL_OFS)
             || (aw_addr == ATS_STATUS_OFS) || (aw_addr == ATS_FLAG_OFS);
    wr_count   = wr_go && w_strb[0] && (aw_addr == ATS_COUNT_OFS);
    wr_compare = wr_go && w_strb[0] && (aw_addr == ATS_COMPARE_OFS);
    wr_control = wr_go && w_strb[0] && (aw_addr == ATS_CONTROL_OFS);
    wr_status  = wr_go && w_strb[0] && (aw_addr == ATS_STATUS_OFS);
    wr_flag    = wr_go && w_strb[0] && (aw_addr == ATS_FLAG_OFS);
  end

  // address and data are taken in either order
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      aw_held           <= 1'b0;
      aw_addr           <= 8'h00;
      s_axi_awready_out <= 1'b0;
    end
    else if (s_axi_awvalid_in && s_axi_awready_out)
    begin
      aw_held           <= 1'b1;
      aw_addr           <= {s_axi_awaddr_in[7:2], 2'h0};
      s_axi_awready_out <= 1'b0;
    end
    else if (wr_go)
    begin
      aw_held           <= 1'b0;
      s_axi_awready_out <= 1'b1;
    end
    else
      s_axi_awready_out <= !aw_held;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      w_held           <= 1'b0;
      w_data           <= 32'h0000_0000;
      w_strb           <= 4'h0;
      s_axi_wready_out <= 1'b0;
    end
    else if (s_axi_wvalid_in && s_axi_wready_out)
    begin
      w_held           <= 1'b1;
      w_data           <= s_axi_wdata_in;
      w_strb           <= s_axi_wstrb_in;
      s_axi_wready_out <= 1'b0;
    end
    else if (wr_go)
    begin
      w_held           <= 1'b0;
      s_axi_wready_out <= 1'b1;
    end
    else
      s_axi_wready_out <= !w_held;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= ATS_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= wr_hit ? ATS_RESP_OKAY : ATS_RESP_SLVERR;
    end
    else if (s_axi_bready_in)
      s_axi_bvalid_out <= 1'b0;
  end

  // ---------------- oscillator sampling ----------------
  logic osc_sync;
  logic osc_prev;
  logic osc_edge;

  // R22: oscillator through two flops
  ats_sync2 #(.WIDTH(1)) u_osc_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in (timer_osc_in),
    .sync_out (osc_sync)
  );

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      osc_prev <= 1'b0;
    else
      osc_prev <= osc_sync;
  end

  assign osc_edge = osc_sync && !osc_prev;

  // ---------------- holding registers ----------------
  logic       async_sel;
  logic [7:0] count_hold;
  logic [7:0] compare_hold;
  logic [7:0] control_hold;
  logic       count_busy;
  logic       compare_busy;
  logic       control_busy;
  logic       count_commit;
  logic       compare_commit;
  logic       control_commit;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      async_sel <= 1'b0;
    else if (wr_status)
      async_sel <= wbyte[ATS_ASYNC_SEL_BIT];
  end

  // R6: count holding, latched after two osc edges
  // R7: independent path per register
  // R21: count busy set and cleared
  ats_hold_xfer u_count_xfer (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .write_in     (wr_count),
    .wdata_in     (wbyte),
    .async_sel_in (async_sel),
    .osc_edge_in  (osc_edge),
    .hold_out     (count_hold),
    .busy_out     (count_busy),
    .commit_out   (count_commit)
  );

  // R21: compare busy set and cleared
  ats_hold_xfer u_compare_xfer (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .write_in     (wr_compare),
    .wdata_in     (wbyte),
    .async_sel_in (async_sel),
    .osc_edge_in  (osc_edge),
    .hold_out     (compare_hold),
    .busy_out     (compare_busy),
    .commit_out   (compare_commit)
  );

  // R1: control write sets control busy
  // R2: busy clears on transfer to control
  ats_hold_xfer u_control_xfer (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .write_in     (wr_control),
    .wdata_in     (wbyte),
    .async_sel_in (async_sel),
    .osc_edge_in  (osc_edge),
    .hold_out     (control_hold),
    .busy_out     (control_busy),
    .commit_out   (control_commit)
  );

  // ---------------- timer domain registers ----------------
  logic [7:0]    count;
  logic [7:0]    compare;
  logic [7:0]    control;
  logic [9:0]    prescale;
  logic          src_tick;
  logic          tick;
  logic          prescale_hit;
  logic          match;
  logic          overflow;
  ats_cmp_mode_t cmp_mode;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      compare <= ATS_REG_RESET;
      control <= ATS_REG_RESET;
    end
    else
    begin
      if (compare_commit)
        compare <= compare_hold;
      if (control_commit)
        control <= control_hold;
    end
  end

  // R20: source is the oscillator edge or every system clock
  assign src_tick = async_sel ? osc_edge : 1'b1;

  always_comb
  begin
    case (control[ATS_CLK_SEL_LSB +: 3])
      3'h0:    prescale_hit = 1'b0;
      3'h1:    prescale_hit = 1'b1;
      3'h2:    prescale_hit = (prescale[2:0] == 3'h7);
      3'h3:    prescale_hit = (prescale[4:0] == 5'h1F);
      3'h4:    prescale_hit = (prescale[5:0] == 6'h3F);
      3'h5:    prescale_hit = (prescale[6:0] == 7'h7F);
      3'h6:    prescale_hit = (prescale[7:0] == 8'hFF);
      default: prescale_hit = (prescale == 10'h3FF);
    endcase
  end

  assign tick = src_tick && prescale_hit;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      prescale <= 10'h000;
    else if (src_tick)
      prescale <= prescale + 10'h001;
  end

  // R10: no match while count or compare transfer pending
  assign match    = tick && !count_busy && !compare_busy && !count_commit && !compare_commit
                    && (count + 8'h01 == compare);
  assign overflow = tick && (count == 8'hFF);
  assign cmp_mode = ats_cmp_mode_t'(control[ATS_CMP_MODE_LSB +: 2]);

  // a committed count wins over the increment in the same cycle
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      count <= ATS_REG_RESET;
    else if (count_commit)
      count <= count_hold;
    else if (match && control[ATS_CTC_BIT])
      count <= 8'h00;
    else if (tick)
      count <= count + 8'h01;
  end

  // R19: pin updated on timer ticks only
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      compare_pin_out <= 1'b0;
    else if (match)
    begin
      case (cmp_mode)
        ATS_CMP_TOGGLE: compare_pin_out <= !compare_pin_out;
        ATS_CMP_CLEAR:  compare_pin_out <= 1'b0;
        ATS_CMP_SET:    compare_pin_out <= 1'b1;
        default:        compare_pin_out <= compare_pin_out;
      endcase
    end
  end

  // ---------------- flag crossing and wake ----------------
  logic [ATS_FLAG_DELAY-1:0] ovf_pipe;
  logic [ATS_FLAG_DELAY-1:0] cmp_pipe;
  logic                      overflow_flag;
  logic                      compare_flag;
  logic                      event_pending;

  // R18: flag surfaces four cpu cycles after the timer event
  // R17: delay counts from the timer event, not from the wake
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      ovf_pipe <= '0;
      cmp_pipe <= '0;
    end
    else
    begin
      ovf_pipe <= {ovf_pipe[ATS_FLAG_DELAY-2:0], overflow};
      cmp_pipe <= {cmp_pipe[ATS_FLAG_DELAY-2:0], match};
    end
  end

  // write one clears; a set in the same cycle wins
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      overflow_flag <= 1'b0;
      compare_flag  <= 1'b0;
    end
    else
    begin
      if (ovf_pipe[ATS_FLAG_DELAY-1])
        overflow_flag <= 1'b1;
      else if (wr_flag && wbyte[ATS_OVF_FLAG_BIT])
        overflow_flag <= 1'b0;
      if (cmp_pipe[ATS_FLAG_DELAY-1])
        compare_flag <= 1'b1;
      else if (wr_flag && wbyte[ATS_CMP_FLAG_BIT])
        compare_flag <= 1'b0;
    end
  end

  // R16: wake on the timer tick after the condition
  // R12: pending rearms only on a following tick
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      event_pending <= 1'b0;
      wake_out      <= 1'b0;
    end
    else
    begin
      if (overflow || match)
        event_pending <= 1'b1;
      else if (src_tick)
        event_pending <= 1'b0;
      wake_out <= event_pending && src_tick && power_save_in;
    end
  end

  // R13: oscillator kept running while async selected, except in power-down
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      osc_enable_out <= 1'b0;
    else
      osc_enable_out <= async_sel && !power_down_in;
  end

  // ---------------- read path ----------------
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    rd_hit     = 1'b1;
    case ({s_axi_araddr_in[7:2], 2'h0})
      // R4: live counter
      ATS_COUNT_OFS:   next_rdata[7:0] = count;
      // R5: holding registers read back
      ATS_COMPARE_OFS: next_rdata[7:0] = compare_hold;
      ATS_CONTROL_OFS: next_rdata[7:0] = control_hold;
      ATS_STATUS_OFS:  next_rdata[3:0] = {async_sel, count_busy, compare_busy, control_busy};
      ATS_FLAG_OFS:    next_rdata[1:0] = {compare_flag, overflow_flag};
      default:         rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= ATS_RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= next_rdata;
      s_axi_rresp_out   <= rd_hit ? ATS_RESP_OKAY : ATS_RESP_SLVERR;
    end
    else if (s_axi_rvalid_out)
    begin
      if (s_axi_rready_in)
        s_axi_rvalid_out <= 1'b0;
    end
    else
      s_axi_arready_out <= 1'b1;
  end
endmodule
`default_nettype wire

// File: dv/ats_chk_monitor.sv
// port-level checker for the timer update crossing block
`timescale 1ns/1ps
`default_nettype none
module ats_chk (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  // register bus
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  // sleep and oscillator
  input wire logic        power_save_in,
  input wire logic        power_down_in,
  input wire logic        osc_enable_out,
  input wire logic        wake_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_wr_taken;
    s_axi_awvalid_in && s_axi_awready_out ##[0:2] s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  AST_OSC_STOP: assert property (power_down_in |=> !osc_enable_out)
    else $error("oscillator left enabled in power-down");
  AST_WAKE_SAVE: assert property ($rose(wake_out) |-> $past(power_save_in))
    else $error("wake request outside power-save");
  AST_WAKE_PULSE: assert property (wake_out |=> !wake_out)
    else $error("wake request longer than one cycle");
  AST_RD_LAT: assert property (s_rd_taken |-> ##[1:2] s_axi_rvalid_out)
    else $error("read answer late");
  AST_RD_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped before accepted");
  AST_AR_BLOCK: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read address taken while read pending");
  AST_WR_RESP: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid_out)
    else $error("write response late");
  AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped before accepted");
endmodule
bind ats_top ats_chk ats_chk_i (.clk_in, .rst_n_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in,
  .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in, .power_save_in, .power_down_in, .osc_enable_out, .wake_out);
`default_nettype wire

// File: dv/ats_osc_model.sv
// low-frequency timer oscillator model
`timescale 1ns/1ps
`default_nettype none
module ats_osc_model (
  // control
  input wire logic enable_in,
  // clock out
  output var logic osc_out
);
  // stable at once
  // toggles only while enabled, parked low otherwise; the start offset keeps edges off the cpu clock edges
  initial
  begin
    osc_out = 1'h0;
    #1.3;
    forever
    begin
      #62.5;
      osc_out = enable_in ? ~osc_out : 1'h0;
    end
  end
endmodule
`default_nettype wire

// File: dv/ats_top_tb_top.sv
// testbench for the timer update crossing block
`timescale 1ns/1ps
`default_nettype none
module ats_top_tb_top;
  import ats_pkg::*;
  logic        clk_in   = 1'h0;
  logic        rst_n_in = 1'h0;
  logic [7:0]  awaddr   = 8'h00;
  logic        awvalid  = 1'h0;
  logic [31:0] wdata    = 32'h0;
  logic        wvalid   = 1'h0;
  logic        bready   = 1'h0;
  logic [7:0]  araddr   = 8'h00;
  logic        arvalid  = 1'h0;
  logic        rready   = 1'h0;
  logic        psave    = 1'h0;
  logic        pdown    = 1'h0;
  logic [31:0] v;
  logic [31:0] a;
  wire logic   awready, wready, bvalid, arready, rvalid, osc, pin, osc_en, wake;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int n_mismatch = 0;
  int cmp_count  = 0;
  int cyc        = 0;
  int edges      = 0;
  int e0;
  int k;
  always #2.5 clk_in = ~clk_in;
  always @(posedge osc) edges <= edges + 1;
  ats_osc_model ats_osc_model_i (.enable_in(osc_en), .osc_out(osc));
  ats_top ats_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .timer_osc_in(osc),
    .power_save_in(psave), .power_down_in(pdown), .compare_pin_out(pin), .osc_enable_out(osc_en),
    .wake_out(wake));
  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one write; address and data offered together, each released when taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    logic ta;
    logic tw;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge clk_in);
    awaddr <= ad;
    awvalid <= 1'h1;
    wdata <= d;
    wvalid <= 1'h1;
    while (!(ta && tw))
    begin
      @(posedge clk_in);
      if (!ta && awready)
      begin
        awvalid <= 1'h0;
        ta = 1'h1;
      end
      if (!tw && wready)
      begin
        wvalid <= 1'h0;
        tw = 1'h1;
      end
    end
    while (!bvalid) @(posedge clk_in);
    // late ready, so the response has to stand a cycle
    bready <= 1'h1;
    do @(posedge clk_in); while (!bvalid);
    bready <= 1'h0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d, input logic [1:0] er);
    @(posedge clk_in);
    araddr <= ad;
    arvalid <= 1'h1;
    do @(posedge clk_in); while (!arready);
    arvalid <= 1'h0;
    while (!rvalid) @(posedge clk_in);
    // late ready, so the read data has to stand a cycle
    rready <= 1'h1;
    do @(posedge clk_in); while (!rvalid);
    d = rdata;
    rready <= 1'h0;
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask
  // poll status until only the async select bit remains
  // no rewrite while busy
  task automatic wait_idle();
    k = 0;
    do
    begin
      rd(ATS_STATUS_OFS, v, ATS_RESP_OKAY);
      k++;
    end
    while (v !== 32'h8 && k < 60);
    chk("status idle", v, 32'h8);
  endtask
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'h1;
    rd(ATS_STATUS_OFS, v, ATS_RESP_OKAY);
    chk("status reset", v, 32'h0);
    wr(ATS_COMPARE_OFS, 32'h5A, ATS_RESP_OKAY);
    rd(ATS_COMPARE_OFS, v, ATS_RESP_OKAY);
    chk("compare sync", v, 32'h5A);
    rd(ATS_STATUS_OFS, v, ATS_RESP_OKAY);
    chk("no busy sync", v, 32'h0);
    wr(8'h14, 32'hFF, ATS_RESP_SLVERR);
    rd(8'h14, v, ATS_RESP_SLVERR);
    chk("unmapped", v, 32'h0);
    wr(ATS_STATUS_OFS, 32'h8, ATS_RESP_OKAY);
    rd(ATS_STATUS_OFS, v, ATS_RESP_OKAY);
    chk("async select", v, 32'h8);
    wr(ATS_CONTROL_OFS, 32'h30, ATS_RESP_OKAY);
    e0 = edges;
    rd(ATS_STATUS_OFS, v, ATS_RESP_OKAY);
    chk("control busy", v, 32'h9);
    rd(ATS_CONTROL_OFS, v, ATS_RESP_OKAY);
    chk("control holding", v, 32'h30);
    wait_idle();
    chk("osc edges", 32'((edges - e0) >= 1 && (edges - e0) <= 3), 32'h1);
    wr(ATS_COUNT_OFS, 32'h20, ATS_RESP_OKAY);
    wr(ATS_COMPARE_OFS, 32'h21, ATS_RESP_OKAY);
    rd(ATS_STATUS_OFS, v, ATS_RESP_OKAY);
    chk("two busy", v, 32'hE);
    wait_idle();
    rd(ATS_COUNT_OFS, v, ATS_RESP_OKAY);
    chk("count landed", v, 32'h20);
    rd(ATS_COMPARE_OFS, v, ATS_RESP_OKAY);
    chk("compare landed", v, 32'h21);
    wr(ATS_COUNT_OFS, 32'h0, ATS_RESP_OKAY);
    wr(ATS_COMPARE_OFS, 32'h5, ATS_RESP_OKAY);
    wr(ATS_CONTROL_OFS, 32'h11, ATS_RESP_OKAY);
    wait_idle();
    k = 0;
    do
    begin
      rd(ATS_FLAG_OFS, v, ATS_RESP_OKAY);
      k++;
    end
    while (v[1] !== 1'h1 && k < 100);
    chk("compare flag", {31'h0, v[1]}, 32'h1);
    chk("compare pin", {31'h0, pin}, 32'h1);
    rd(ATS_COUNT_OFS, a, ATS_RESP_OKAY);
    chk("count advanced", 32'(a >= 32'h5), 32'h1);
    repeat (30) @(posedge clk_in);
    rd(ATS_COUNT_OFS, v, ATS_RESP_OKAY);
    chk("live count", 32'(v !== a), 32'h1);
    wr(ATS_FLAG_OFS, 32'h2, ATS_RESP_OKAY);
    rd(ATS_FLAG_OFS, v, ATS_RESP_OKAY);
    chk("flag cleared", {31'h0, v[1]}, 32'h0);
    psave <= 1'h1;
    k = 0;
    do
    begin
      @(posedge clk_in);
      k++;
    end
    while (wake !== 1'h1 && k < 8000);
    chk("wake", {31'h0, wake}, 32'h1);
    psave <= 1'h0;
    rd(ATS_FLAG_OFS, v, ATS_RESP_OKAY);
    chk("overflow flag", {31'h0, v[0]}, 32'h1);
    pdown <= 1'h1;
    repeat (3) @(posedge clk_in);
    chk("osc off", {31'h0, osc_en}, 32'h0);
    pdown <= 1'h0;
    repeat (3) @(posedge clk_in);
    chk("osc on", {31'h0, osc_en}, 32'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
